// ==== hw/vpoc_map.vh ====
// vpoc_map.vh: register map, field positions, reset values, limits
// assumes: included by hw/vpoc_top.v and by the bench monitor and testbench
`ifndef VPOC_MAP_VH
`define VPOC_MAP_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define VPOC_ADR_CTRL     8'h00
`define VPOC_ADR_TRAVEL   8'h04
`define VPOC_ADR_BAND     8'h08
`define VPOC_ADR_PVBAND   8'h0c
`define VPOC_ADR_SETPT    8'h10
`define VPOC_ADR_MANMV    8'h14
`define VPOC_ADR_SAFEMV   8'h18
`define VPOC_ADR_STATUS   8'h1c
`define VPOC_ADR_CALRES   8'h20
// ----------------------------------------------------------------
// control bits
// ----------------------------------------------------------------
`define VPOC_CTL_CAL      0
`define VPOC_CTL_FBMODE   1
`define VPOC_CTL_DIRECT   2
`define VPOC_CTL_MANUAL   3
`define VPOC_CTL_ACT_LO   4
`define VPOC_CTL_ACT_HI   5
`define VPOC_CTL_STOP     6
`define VPOC_ACT_HOLD     2'h0
`define VPOC_ACT_OPEN     2'h1
`define VPOC_ACT_CLOSE    2'h2
// ----------------------------------------------------------------
// reset values and limits, percent in tenths, travel in seconds
// ----------------------------------------------------------------
`define VPOC_TRAVEL_DEF   10'h01e
`define VPOC_TRAVEL_MIN   10'h001
`define VPOC_TRAVEL_MAX   10'h3e7
`define VPOC_BAND_CL_DEF  8'h28
`define VPOC_BAND_FL_DEF  8'h14
`define VPOC_HYST_DEF     8'h08
`define VPOC_BAND_MIN     8'h01
`define VPOC_BAND_MAX     8'h64
`define VPOC_HYST_MAX     8'hc8
`define VPOC_PVB_MAX      16'h7e90
`define VPOC_OPEN_MIN     16'hff9c
`define VPOC_OPEN_MAX     16'h044c
`define VPOC_FULL         16'h03e8
`define VPOC_INVALID      16'h8000
`endif

// ==== hw/vpoc_top.v ====
// vpoc_top.v: position-proportional valve drive with wishbone registers
// assumes: inputs synchronous to sys_clk_i, classic wishbone master
`timescale 1ns/1ns
`include "vpoc_map.vh"
module vpoc_top #(
    parameter CLK_HZ       = 25000000,
    parameter TENTH_CYC    = 25000,
    parameter STALL_CYC    = 25000000,
    parameter FB_W         = 12
) (
    input  wire              sys_clk_i,
    input  wire              rst_b_i,
    input  wire              ce_i,
    input  wire              wb_cyc_i,
    input  wire              wb_stb_i,
    input  wire              wb_we_i,
    input  wire [7:0]        wb_adr_i,
    input  wire [3:0]        wb_sel_i,
    input  wire [31:0]       wb_dat_i,
    output reg  [31:0]       wb_dat_o,
    output reg               wb_ack_o,
    input  wire [FB_W-1:0]   valve_feedback_input_i,
    input  wire              feedback_present_i,
    input  wire              feedback_error_i,
    input  wire              input_error_i,
    input  wire [15:0]       process_value_i,
    input  wire [15:0]       manipulated_value_i,
    input  wire              up_key_i,
    input  wire              down_key_i,
    output reg               valve_open_o,
    output reg               valve_close_o
);
// ----------------------------------------------------------------
// helpers
// ----------------------------------------------------------------
function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  sel;
    integer k;
    begin
        for (k = 0; k < 4; k = k + 1)
            merge[k*8 +: 8] = sel[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
    end
endfunction
function [15:0] clamp_pct;
    input signed [16:0] v;
    begin
        if (v < $signed({1'b1, `VPOC_OPEN_MIN}))
            clamp_pct = `VPOC_OPEN_MIN;
        else if (v > $signed({1'b0, `VPOC_OPEN_MAX}))
            clamp_pct = `VPOC_OPEN_MAX;
        else
            clamp_pct = v[15:0];
    end
endfunction
function [7:0] lim8;
    input [7:0] v;
    input [7:0] hi;
    begin
        if (v < `VPOC_BAND_MIN)
            lim8 = `VPOC_BAND_MIN;
        else if (v > hi)
            lim8 = hi;
        else
            lim8 = v;
    end
endfunction
// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
localparam S_IDLE  = 3'b001;
localparam S_OPEN  = 3'b010;
localparam S_CLOSE = 3'b100;
reg  [6:0]        ctrl;
reg  [9:0]        travel;
reg  [7:0]        band_cl;
reg  [7:0]        band_fl;
reg  [7:0]        hyst;
reg  [15:0]       pv_band;
reg  [15:0]       setpoint;
reg  [15:0]       manual_mv;
reg  [15:0]       safe_mv;
reg  [FB_W-1:0]   pos_closed;
reg  [FB_W-1:0]   pos_open;
reg  [2:0]        cal_st;
reg  [15:0]       est_open;
reg  [24:0]       drive_cnt;
reg  [15:0]       meas_open;
reg  [31:0]       stall_cnt;
reg  [31:0]       sec_cyc;
reg  [9:0]        sec_cnt;
reg  [9:0]        move_secs;
reg  [FB_W-1:0]   fb_last;
wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire wr     = wb_req & wb_we_i;
wire [31:0] band_word = {8'h00, hyst, band_fl, band_cl};
wire [31:0] ctrl_word = {25'h0, ctrl};
wire [31:0] trav_word = {22'h0, travel};
wire [31:0] band_new  = merge(band_word, wb_dat_i, wb_sel_i);
wire [31:0] ctrl_new  = merge(ctrl_word, wb_dat_i, wb_sel_i);
wire [31:0] trav_new  = merge(trav_word, wb_dat_i, wb_sel_i);
wire [31:0] pvb_new   = merge({16'h0, pv_band}, wb_dat_i, wb_sel_i);
wire [31:0] spt_new   = merge({16'h0, setpoint}, wb_dat_i, wb_sel_i);
// ----------------------------------------------------------------
// mode decode
// ----------------------------------------------------------------
wire fb_ok     = feedback_present_i & ~feedback_error_i;
wire floating  = ~ctrl[`VPOC_CTL_FBMODE] | ~feedback_present_i;
wire direct    = ctrl[`VPOC_CTL_DIRECT] & ~floating;
wire fault     = input_error_i | (~floating & feedback_error_i);
wire safe_on   = ctrl[`VPOC_CTL_STOP] | fault;
wire [1:0] act = ctrl[`VPOC_CTL_ACT_HI:`VPOC_CTL_ACT_LO];
wire calib     = ~cal_st[0];
wire [7:0] band = floating ? band_fl : band_cl;
// ----------------------------------------------------------------
// target position
// ----------------------------------------------------------------
wire signed [16:0] dev = $signed({setpoint[15], setpoint})
                       - $signed({process_value_i[15], process_value_i});
wire [16:0] dev_mag = dev[16] ? (~dev + 17'h00001) : dev;
wire in_pvb = dev_mag <= {1'b0, pv_band};
wire signed [16:0] dev_eff = in_pvb ? 17'h00000 : dev;
wire [15:0] auto_tgt = clamp_pct($signed({manipulated_value_i[15],
                                 manipulated_value_i}) + dev_eff);
reg  [15:0] target;
always @*
begin
    if (safe_on)
        target = safe_mv;
    else if (ctrl[`VPOC_CTL_MANUAL])
        target = manual_mv;
    else
        target = auto_tgt;
end
wire [15:0] pos_now = floating ? est_open : meas_open;
wire signed [16:0] err = $signed({target[15], target})
                       - $signed({pos_now[15], pos_now});
wire signed [16:0] s_band = $signed({9'h000, band});
wire signed [16:0] s_off  = (band > hyst) ? $signed({9'h000, band - hyst})
                                          : 17'sh00000;
// ----------------------------------------------------------------
// output decision
// ----------------------------------------------------------------
reg next_open;
reg next_close;
always @*
begin
    next_open  = valve_open_o;
    next_close = valve_close_o;
    if (calib)
    begin
        next_open  = cal_st[1];
        next_close = cal_st[2];
    end
    else if (safe_on & ~direct)
    begin
        next_open  = act == `VPOC_ACT_OPEN;
        next_close = act == `VPOC_ACT_CLOSE;
        if (act == `VPOC_ACT_HOLD)
        begin
            next_open  = 1'b0;
            next_close = 1'b0;
        end
    end
    else if (ctrl[`VPOC_CTL_MANUAL] & ~direct)
    begin
        next_open  = up_key_i & ~down_key_i;
        next_close = down_key_i & ~up_key_i;
    end
    else
    begin
        if (err > s_band)
            next_open = 1'b1;
        else if (err < s_off)
            next_open = 1'b0;
        if (err < -s_band)
            next_close = 1'b1;
        else if (err > -s_off)
            next_close = 1'b0;
    end
    if (next_open & next_close)
        next_close = 1'b0;
end
// ----------------------------------------------------------------
// measured opening divider
// ----------------------------------------------------------------
wire [FB_W:0] span = {1'b0, pos_open} - {1'b0, pos_closed};
wire neg_fb = valve_feedback_input_i < pos_closed;
wire [FB_W-1:0] off_fb = neg_fb ? pos_closed - valve_feedback_input_i
                                : valve_feedback_input_i - pos_closed;
reg  [31:0] dv_num;
reg  [FB_W:0] dv_rem;
reg  [31:0] dv_q;
reg  [5:0]  dv_i;
reg         dv_neg;
wire [FB_W+1:0] dv_try = {dv_rem, dv_num[31]} - {1'b0, span};
wire [16:0] q_s = dv_neg ? (17'h00000 - {1'b0, dv_q[15:0]})
                         : {1'b0, dv_q[15:0]};
// ----------------------------------------------------------------
// state
// ----------------------------------------------------------------
always @(posedge sys_clk_i or negedge rst_b_i)
begin
    if (!rst_b_i)
    begin
        ctrl          <= 7'h00;
        travel        <= `VPOC_TRAVEL_DEF;
        band_cl       <= `VPOC_BAND_CL_DEF;
        band_fl       <= `VPOC_BAND_FL_DEF;
        hyst          <= `VPOC_HYST_DEF;
        pv_band       <= 16'h0000;
        setpoint      <= 16'h0000;
        manual_mv     <= 16'h0000;
        safe_mv       <= 16'h0000;
        pos_closed    <= {FB_W{1'b0}};
        pos_open      <= {FB_W{1'b1}};
        cal_st        <= S_IDLE;
        est_open      <= 16'h0000;
        drive_cnt     <= 25'h0000000;
        meas_open     <= 16'h0000;
        stall_cnt     <= 32'h00000000;
        sec_cyc       <= 32'h00000000;
        sec_cnt       <= 10'h000;
        move_secs     <= 10'h000;
        fb_last       <= {FB_W{1'b0}};
        dv_num        <= 32'h00000000;
        dv_rem        <= {(FB_W+1){1'b0}};
        dv_q          <= 32'h00000000;
        dv_i          <= 6'h00;
        dv_neg        <= 1'b0;
        wb_ack_o      <= 1'b0;
        wb_dat_o      <= 32'h00000000;
        valve_open_o  <= 1'b0;
        valve_close_o <= 1'b0;
    end
    else if (ce_i)
    begin
        wb_ack_o      <= wb_req;
        valve_open_o  <= next_open;
        valve_close_o <= next_close;
        if (wr)
        begin
            if (wb_adr_i == `VPOC_ADR_CTRL)
                ctrl <= ctrl_new[6:0] | {6'h00, ctrl[0]};
            else if (wb_adr_i == `VPOC_ADR_TRAVEL)
            begin
                if (trav_new[9:0] < `VPOC_TRAVEL_MIN)
                    travel <= `VPOC_TRAVEL_MIN;
                else if (trav_new[9:0] > `VPOC_TRAVEL_MAX)
                    travel <= `VPOC_TRAVEL_MAX;
                else
                    travel <= trav_new[9:0];
            end
            else if (wb_adr_i == `VPOC_ADR_BAND)
            begin
                band_cl <= lim8(band_new[7:0], `VPOC_BAND_MAX);
                band_fl <= lim8(band_new[15:8], `VPOC_BAND_MAX);
                hyst    <= lim8(band_new[23:16], `VPOC_HYST_MAX);
            end
            else if (wb_adr_i == `VPOC_ADR_PVBAND)
                pv_band <= (pvb_new[15:0] > `VPOC_PVB_MAX) ? `VPOC_PVB_MAX
                                                           : pvb_new[15:0];
            else if (wb_adr_i == `VPOC_ADR_SETPT)
                setpoint <= spt_new[15:0];
            else if (wb_adr_i == `VPOC_ADR_MANMV)
                manual_mv <= clamp_pct({wb_dat_i[15], wb_dat_i[15:0]});
            else if (wb_adr_i == `VPOC_ADR_SAFEMV)
                safe_mv <= clamp_pct({wb_dat_i[15], wb_dat_i[15:0]});
        end
        if (wb_req & ~wb_we_i)
        begin
            if (wb_adr_i == `VPOC_ADR_CTRL)
                wb_dat_o <= ctrl_word;
            else if (wb_adr_i == `VPOC_ADR_TRAVEL)
                wb_dat_o <= trav_word;
            else if (wb_adr_i == `VPOC_ADR_BAND)
                wb_dat_o <= band_word;
            else if (wb_adr_i == `VPOC_ADR_PVBAND)
                wb_dat_o <= {16'h0000, pv_band};
            else if (wb_adr_i == `VPOC_ADR_SETPT)
                wb_dat_o <= {16'h0000, setpoint};
            else if (wb_adr_i == `VPOC_ADR_MANMV)
                wb_dat_o <= {16'h0000, manual_mv};
            else if (wb_adr_i == `VPOC_ADR_SAFEMV)
                wb_dat_o <= {16'h0000, safe_mv};
            else if (wb_adr_i == `VPOC_ADR_STATUS)
                wb_dat_o <= {fb_ok ? meas_open : `VPOC_INVALID,
                             11'h000, fb_ok, floating, calib,
                             valve_close_o, valve_open_o};
            else if (wb_adr_i == `VPOC_ADR_CALRES)
                wb_dat_o <= {{(16-FB_W){1'b0}}, pos_open,
                             {(16-FB_W){1'b0}}, pos_closed};
            else
                wb_dat_o <= 32'h00000000;
        end
        // calibration sequence
        fb_last <= valve_feedback_input_i;
        if (fb_last != valve_feedback_input_i)
        begin
            stall_cnt <= 32'h00000000;
            move_secs <= sec_cnt;
        end
        else
            stall_cnt <= stall_cnt + 32'h00000001;
        if (sec_cyc >= CLK_HZ - 1)
        begin
            sec_cyc <= 32'h00000000;
            sec_cnt <= sec_cnt + 10'h001;
        end
        else
            sec_cyc <= sec_cyc + 32'h00000001;
        case (cal_st)
            S_IDLE:
                if (ctrl[`VPOC_CTL_CAL] & fb_ok)
                begin
                    cal_st    <= S_OPEN;
                    stall_cnt <= 32'h00000000;
                end
            S_OPEN:
                if (stall_cnt >= STALL_CYC - 1)
                begin
                    pos_open  <= valve_feedback_input_i;
                    cal_st    <= S_CLOSE;
                    stall_cnt <= 32'h00000000;
                    sec_cyc   <= 32'h00000000;
                    sec_cnt   <= 10'h000;
                    move_secs <= 10'h000;
                end
            S_CLOSE:
                if (stall_cnt >= STALL_CYC - 1)
                begin
                    pos_closed <= valve_feedback_input_i;
                    travel     <= (move_secs < `VPOC_TRAVEL_MIN) ?
                                  `VPOC_TRAVEL_MIN : move_secs;
                    est_open   <= 16'h0000;
                    ctrl[`VPOC_CTL_CAL] <= 1'b0;
                    cal_st     <= S_IDLE;
                end
            default:
                cal_st <= S_IDLE;
        endcase
        if (!fb_ok & calib)
        begin
            cal_st <= S_IDLE;
            ctrl[`VPOC_CTL_CAL] <= 1'b0;
        end
        // floating estimate, one tenth per travel/1000
        if (valve_open_o | valve_close_o)
        begin
            if (drive_cnt >= travel * TENTH_CYC - 1)
            begin
                drive_cnt <= 25'h0000000;
                if (valve_open_o & est_open != `VPOC_FULL)
                    est_open <= est_open + 16'h0001;
                else if (valve_close_o & est_open != 16'h0000)
                    est_open <= est_open - 16'h0001;
            end
            else
                drive_cnt <= drive_cnt + 25'h0000001;
        end
        // measured opening, 32 divide steps, restarted every 34 cycles
        if (dv_i == 6'h00)
        begin
            dv_num <= {{(32-FB_W){1'b0}}, off_fb} * {16'h0000, `VPOC_FULL};
            dv_rem <= {(FB_W+1){1'b0}};
            dv_q   <= 32'h00000000;
            dv_neg <= neg_fb;
            dv_i   <= 6'h01;
        end
        else if (dv_i == 6'h21)
        begin
            if (span != {(FB_W+1){1'b0}})
                meas_open <= clamp_pct(q_s);
            dv_i <= 6'h00;
        end
        else
        begin
            dv_num <= {dv_num[30:0], 1'b0};
            if (!dv_try[FB_W+1])
            begin
                dv_rem <= dv_try[FB_W:0];
                dv_q   <= {dv_q[30:0], 1'b1};
            end
            else
            begin
                dv_rem <= {dv_rem[FB_W-1:0], dv_num[31]};
                dv_q   <= {dv_q[30:0], 1'b0};
            end
            dv_i <= dv_i + 6'h01;
        end
    end
end
endmodule // vpoc_top

// ==== bench/vpoc_top_monitor.sv ====
// vpoc_top_monitor.sv: port assertions for vpoc_top
// assumes: bound into vpoc_top, classic wishbone master on the bus
`timescale 1ns/1ns
`include "vpoc_map.vh"
module vpoc_top_monitor (
    input wire        sys_clk_i,
    input wire        rst_b_i,
    input wire        ce_i,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [7:0]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        feedback_present_i,
    input wire        feedback_error_i,
    input wire        input_error_i,
    input wire        up_key_i,
    input wire        down_key_i,
    input wire        valve_open_o,
    input wire        valve_close_o
);
    reg  [7:0] ctrl;
    reg  [5:0] bad_cnt;
    wire       take;
    wire       man_ok;
    wire       rd_stat;
    assign take = ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign man_ok = ce_i && ctrl[3] && !ctrl[2] && !ctrl[6] && !ctrl[0]
                    && !input_error_i;
    assign rd_stat = wb_ack_o && !wb_we_i
                     && wb_adr_i == `VPOC_ADR_STATUS && bad_cnt == 6'h3f;
    // shadow of control bits, taken at the same edge as the design
    always @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ctrl    <= 8'h00;
            bad_cnt <= 6'h00;
        end
        else
        begin
            if (take && wb_we_i && wb_adr_i == `VPOC_ADR_CTRL && wb_sel_i[0])
                ctrl <= wb_dat_i[7:0];
            if (feedback_present_i && !feedback_error_i)
                bad_cnt <= 6'h00;
            else if (bad_cnt != 6'h3f)
                bad_cnt <= bad_cnt + 6'h01;
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_req;
        take;
    endsequence
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    chk_ack_timing: assert property (s_req |=> s_ack_pulse)
        else $error("ack not a single pulse one cycle after request");
    chk_ack_cause: assert property ($rose(wb_ack_o) |->
        $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    chk_never_both: assert property (!(valve_open_o && valve_close_o))
        else $error("open and close high together");
    chk_up_open: assert property (man_ok && up_key_i && !down_key_i
        |=> valve_open_o) else $error("up key did not open");
    chk_up_release: assert property (man_ok && !up_key_i |=> !valve_open_o)
        else $error("open without up key");
    chk_down_close: assert property (man_ok && down_key_i && !up_key_i
        |=> valve_close_o) else $error("down key did not close");
    chk_down_release: assert property (man_ok && !down_key_i
        |=> !valve_close_o) else $error("close without down key");
    chk_safe_hold: assert property (ce_i && !ctrl[0] && !(ctrl[2] && ctrl[1])
        && ctrl[5:4] == 2'h0 && (ctrl[6] || input_error_i)
        |=> !valve_open_o && !valve_close_o) else $error("hold drove valve");
    chk_unmapped_zero: assert property ($rose(wb_ack_o) && !wb_we_i
        && wb_adr_i > `VPOC_ADR_CALRES |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    chk_invalid_open: assert property (rd_stat
        |-> wb_dat_o[31:16] == `VPOC_INVALID) else $error("opening not invalid");
    chk_float_forced: assert property (rd_stat && !feedback_present_i
        |-> wb_dat_o[3]) else $error("floating not forced");
endmodule // vpoc_top_monitor
bind vpoc_top vpoc_top_monitor vpoc_top_monitor_i (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .feedback_present_i(feedback_present_i),
    .feedback_error_i(feedback_error_i), .input_error_i(input_error_i),
    .up_key_i(up_key_i), .down_key_i(down_key_i),
    .valve_open_o(valve_open_o), .valve_close_o(valve_close_o));

// ==== bench/vpoc_valve_model.sv ====
// vpoc_valve_model.sv: motor valve with potentiometer
// assumes: open/close levels from the drive, one step every two cycles
`timescale 1ns/1ns
module vpoc_valve_model #(
    parameter FB_W   = 12,
    parameter LO_END = 12'h200,
    parameter HI_END = 12'he80
) (
    input  wire            sys_clk_i,
    input  wire            present_i,
    input  wire            open_i,
    input  wire            close_i,
    output wire [FB_W-1:0] fb_o
);
    reg [FB_W-1:0] pos;
    reg [FB_W-1:0] noise;
    reg            half;
    initial
    begin
        pos   = 12'h800;
        noise = 12'h000;
        half  = 1'b0;
    end
    // stalls at the end stops; unplugged wiper floats
    always @(posedge sys_clk_i)
    begin
        half  <= ~half;
        noise <= ~noise;
        if (half && open_i && !close_i && pos < HI_END)
            pos <= pos + 12'h001;
        else if (half && close_i && !open_i && pos > LO_END)
            pos <= pos - 12'h001;
    end
    assign fb_o = present_i ? pos : noise;
endmodule // vpoc_valve_model

// ==== bench/vpoc_top_tb.sv ====
// vpoc_top_tb.sv: self-checking bench for vpoc_top
// assumes: vpoc_valve_model as far side, monitor bound in
`timescale 1ns/1ns
`include "vpoc_map.vh"
module vpoc_top_tb;
    reg         sys_clk_i;
    reg         rst_b_i;
    reg         cyc;
    reg         we;
    reg  [7:0]  adr;
    reg  [31:0] wdat;
    reg         present;
    reg         fb_err;
    reg         in_err;
    reg         up;
    reg         down;
    reg  [15:0] pv;
    reg  [15:0] mv;
    wire [31:0] rdat;
    wire        ack;
    wire [11:0] fb;
    wire        v_open;
    wire        v_close;
    integer     fail_count;
    integer     n_checks;
    integer     cycles;
    integer     seed;
    integer     i;
    reg  [31:0] q;
    reg  [63:0] e;
    reg  [63:0] exp_q [$];
    vpoc_top #(.CLK_HZ(100), .TENTH_CYC(2), .STALL_CYC(20)) vpoc_top_i (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .valve_feedback_input_i(fb), .feedback_present_i(present),
        .feedback_error_i(fb_err), .input_error_i(in_err),
        .process_value_i(pv), .manipulated_value_i(mv),
        .up_key_i(up), .down_key_i(down),
        .valve_open_o(v_open), .valve_close_o(v_close));
    vpoc_valve_model vpoc_valve_model_i (.sys_clk_i(sys_clk_i),
        .present_i(present), .open_i(v_open), .close_i(v_close), .fb_o(fb));
    task check(input [31:0] seen, input [31:0] want);
    begin
        n_checks = n_checks + 1;
        if (seen !== want)
        begin
            fail_count = fail_count + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    end
    endtask
    task end_of_test;
    begin
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask
    // one classic cycle; reads note {mask, expected}
    task wb(input w, input [7:0] a, input [31:0] d, input [31:0] m);
    begin
        if (!w)
            exp_q.push_back({m, d});
        @(posedge sys_clk_i);
        cyc  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        @(posedge sys_clk_i);
        while (ack !== 1'b1)
            @(posedge sys_clk_i);
        q = rdat;
        cyc <= 1'b0;
    end
    endtask
    task wait_n(input integer n);
    begin
        repeat (n) @(posedge sys_clk_i);
    end
    endtask
    always @(posedge sys_clk_i)
    begin
        cycles = cycles + 1;
        if (cycles == 40000)
        begin
            fail_count = fail_count + 1;
            end_of_test;
        end
        if (ack === 1'b1 && !we && exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            check(rdat & e[63:32], e[31:0]);
        end
    end
    initial
    begin
        sys_clk_i = 1'b0;
        forever
            #20 sys_clk_i = ~sys_clk_i;
    end
    initial
    begin
        {rst_b_i, cyc, we, fb_err, in_err, up, down} = 7'h00;
        {pv, mv} = 32'h0;
        adr = 8'h00;
        wdat = 32'h0;
        present = 1'b1;
        fail_count = 0;
        n_checks = 0;
        cycles = 0;
        seed = 10287;
        wait_n(16);
        rst_b_i <= 1'b1;
        wb(0, `VPOC_ADR_CTRL, 32'h0, 32'hffffffff);
        wb(0, `VPOC_ADR_TRAVEL, 32'h1e, 32'hffffffff);
        wb(0, `VPOC_ADR_BAND, 32'h00081428, 32'hffffffff);
        wb(0, `VPOC_ADR_PVBAND, 32'h0, 32'hffffffff);
        wb(0, `VPOC_ADR_CALRES, 32'h0fff0000, 32'hffffffff);
        wb(0, 8'h24, 32'h0, 32'hffffffff);
        wb(1, `VPOC_ADR_TRAVEL, 32'h0, 32'h0);
        wb(0, `VPOC_ADR_TRAVEL, 32'h1, 32'hffffffff);
        wb(1, `VPOC_ADR_TRAVEL, 32'h3e8, 32'h0);
        wb(0, `VPOC_ADR_TRAVEL, 32'h3e7, 32'hffffffff);
        wb(1, `VPOC_ADR_BAND, 32'h0, 32'h0);
        wb(0, `VPOC_ADR_BAND, 32'h00010101, 32'hffffffff);
        wb(1, `VPOC_ADR_BAND, 32'h00ffffff, 32'h0);
        wb(0, `VPOC_ADR_BAND, 32'h00c86464, 32'hffffffff);
        wb(1, `VPOC_ADR_PVBAND, 32'hffff, 32'h0);
        wb(0, `VPOC_ADR_PVBAND, 32'h7e90, 32'hffffffff);
        i = 1 + ({$random(seed)} % 999);
        wb(1, `VPOC_ADR_TRAVEL, i, 32'h0);
        wb(0, `VPOC_ADR_TRAVEL, i, 32'hffffffff);
        wb(1, `VPOC_ADR_CTRL, 32'h1, 32'h0);
        q = 32'h4;
        for (i = 0; i < 200 && q[2] !== 1'b0; i = i + 1)
        begin
            wait_n(100);
            wb(0, `VPOC_ADR_STATUS, 32'h0, 32'h0);
        end
        wb(0, `VPOC_ADR_CTRL, 32'h0, 32'h1);
        // close stroke 3200 steps, 2 cycles each, 100 cycles a second
        wb(0, `VPOC_ADR_TRAVEL, 32'h40, 32'hffffffff);
        wb(0, `VPOC_ADR_CALRES, 32'h0e800200, 32'h0fff0fff);
        wb(1, `VPOC_ADR_CTRL, 32'h8, 32'h0);
        down <= 1'b1;
        wait_n(3);
        check(v_close, 1'b1);
        wait_n(100);
        down <= 1'b0;
        wait_n(40);
        wb(0, `VPOC_ADR_STATUS, 32'h0, 32'hffff0000);
        up <= 1'b1;
        wait_n(3);
        check(v_open, 1'b1);
        wait_n(7000);
        up <= 1'b0;
        wait_n(40);
        check(v_open, 1'b0);
        wb(0, `VPOC_ADR_STATUS, 32'h03e80000, 32'hffff0000);
        wb(1, `VPOC_ADR_CTRL, 32'h50, 32'h0);
        wait_n(3);
        check(v_open, 1'b1);
        wb(1, `VPOC_ADR_CTRL, 32'h60, 32'h0);
        wait_n(3);
        check(v_close, 1'b1);
        wb(1, `VPOC_ADR_CTRL, 32'h40, 32'h0);
        wait_n(3);
        check({v_open, v_close}, 2'h0);
        wb(1, `VPOC_ADR_CTRL, 32'h0, 32'h0);
        in_err <= 1'b1;
        wait_n(3);
        check({v_open, v_close}, 2'h0);
        in_err <= 1'b0;
        wb(1, `VPOC_ADR_SAFEMV, 32'h0, 32'h0);
        wb(1, `VPOC_ADR_CTRL, 32'h46, 32'h0);
        wait_n(40);
        check(v_close, 1'b1);
        wb(1, `VPOC_ADR_MANMV, 32'h3e8, 32'h0);
        wb(1, `VPOC_ADR_CTRL, 32'h0e, 32'h0);
        down <= 1'b1;
        wait_n(40);
        check(v_close, 1'b0);
        down <= 1'b0;
        wb(1, `VPOC_ADR_CTRL, 32'h2, 32'h0);
        present <= 1'b0;
        wait_n(80);
        wb(0, `VPOC_ADR_STATUS, 32'h80000008, 32'hffff0008);
        present <= 1'b1;
        fb_err <= 1'b1;
        wait_n(80);
        wb(0, `VPOC_ADR_STATUS, 32'h80000000, 32'hffff0000);
        fb_err <= 1'b0;
        wb(1, `VPOC_ADR_SETPT, 32'h200, 32'h0);
        wb(0, `VPOC_ADR_SETPT, 32'h200, 32'hffffffff);
        // deviation inside the process band: target is mv alone
        i = 32'h300 + ({$random(seed)} % 32000);
        pv <= i[15:0];
        mv <= 16'h03e8;
        wait_n(40);
        check({v_open, v_close}, 2'h0);
        end_of_test;
    end
endmodule // vpoc_top_tb
